// File: include/asc_pkg.sv
// Package: register map, fields, resets and timing for the aux converter
package asc_pkg;

  // Register byte offsets
  localparam logic [7:0] CONTROL_OFF = 8'h00;
  localparam logic [7:0] CONFIG_OFF  = 8'h04;
  localparam logic [7:0] CHANNEL_OFF = 8'h08;
  localparam logic [7:0] RESULT_OFF  = 8'h0C;
  localparam logic [7:0] LINK_OFF    = 8'h10;

  // Control register fields
  localparam int CTL_EN_BIT   = 7;
  localparam int CTL_TM_BIT   = 6;
  localparam int CTL_DONE_BIT = 5;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_SRC_LSB  = 1;

  // Config register fields
  localparam int CFG_DIV_LSB  = 3;
  localparam int CFG_GAIN_LSB = 0;

  // Reset values
  localparam logic [4:0] DIV_RESET  = 5'h1F;
  localparam logic [1:0] GAIN_RESET = 2'h0;
  localparam logic [2:0] SRC_RESET  = 3'h0;
  localparam logic [2:0] CHAN_RESET = 3'h0;

  // Conversion timing in conversion-clock periods
  localparam logic [4:0] TRACK_PERIODS = 5'h03;
  localparam logic [4:0] RESULT_BITS   = 5'h08;

  // Start sources
  localparam logic [2:0] SRC_SOFTWARE = 3'h0;
  localparam logic [2:0] SRC_TIMER3   = 3'h1;
  localparam logic [2:0] SRC_EXT_PIN  = 3'h2;
  localparam logic [2:0] SRC_TIMER2   = 3'h3;
  localparam logic [2:0] SRC_PRIMARY  = 3'h4;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TRACK,
    ST_CONVERT
  } asc_state_t;

  // Trigger inputs from the rest of the chip
  typedef struct packed {
    logic timer3_overflow;
    logic timer2_overflow;
    logic primary_converter_busy;
    logic ext_start_aux;
    logic ext_start_primary;
  } asc_trig_t;

  // Controls to the analog core
  typedef struct packed {
    logic       powered;
    logic       track;
    logic [1:0] gain_select;
    logic [2:0] channel;
    logic       cmp_valid;
    logic [7:0] trial_code;
  } asc_analog_t;

endpackage

// File: hdl/asc_clk_div.sv
// Conversion clock enable divider
`timescale 1ns/10ps
`default_nettype none
module asc_clk_div
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       run,
  input  wire logic [4:0] divider,
  // Tick out, one per conversion clock period
  output logic            tick
);

  logic [4:0] count_reg;

  // Divide by divider plus one
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      count_reg <= 5'h00;
    end else if (count_reg >= divider) begin
      count_reg <= 5'h00;
    end else begin
      count_reg <= count_reg + 5'h01;
    end
  end

  assign tick = run && (count_reg >= divider);

endmodule
`default_nettype wire

// File: hdl/asc_conv_ctrl.sv
// Auxiliary 8-bit SAR converter control with AXI4-Lite registers
// What this block does
// (RULE1) Converter, track-hold and gain stage run only while enable bit is one.
// (RULE2) Conversion clock is system clock divided by divider field plus one.
// (RULE3) Software keeps the conversion clock at or below 7.5 MHz.
// (RULE4) Start-source field picks one of five triggers.
// (RULE5) Start code 010 selects the external start pin.
// (RULE6) Aux pin used when enabled, else primary pin starts both converters.
// (RULE7) Busy bit reads one throughout conversion, zero when done.
// (RULE8) Busy falling edge sets done flag; result then readable.
// (RULE9) Software clears flag, writes busy, polls flag, reads result.
// (RULE10) Normal track mode tracks continuously except during conversion.
// (RULE11) Low-power mode tracks three conversion clocks after start.
// (RULE12) Low-power with pin trigger tracks while pin low, converts on rise.
// (RULE13) Software waits 0.8 us after a mux change before starting.
// (RULE14) Gain field selects 0.5, 1, 2 or 4; resets to 0.5.
// (RULE15) Input mux has eight channels chosen by the channel register.
// (RULE16) Software clears port input-mode bits for converter pins.
// (RULE17) Each result is an 8-bit successive approximation word.
// (RULE18) Code 000 starts on busy write, 001 on Timer 3 overflow.
// (RULE19) Gain encoding 00=0.5, 01=1, 10=2, 11=4.
// (RULE20) Only software clears the completion flag.
// (RULE21) Starts during a conversion are ignored.
// (RULE22) Starts from unselected sources have no effect.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
module asc_conv_ctrl
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Triggers and crossbar state
  input  wire asc_trig_t   trig,
  input  wire logic        aux_pin_enabled,
  // Analog core
  output asc_analog_t      analog,
  input  wire logic        cmp_high,
  // Status
  output logic             conversion_busy,
  output logic             done_event
);

  // Register state
  logic       converter_enable_reg;
  logic       track_mode_select_reg;
  logic       conversion_done_flag_reg;
  logic [2:0] start_source_select_reg;
  logic [4:0] sar_clock_divider_reg;
  logic [1:0] gain_select_reg;
  logic [2:0] channel_select_reg;
  logic [7:0] result_reg;

  // Converter state
  asc_state_t state_reg;
  logic [4:0] step_reg;
  logic [7:0] sar_reg;
  logic       tick;
  logic       busy_clear;

  // Trigger edge history
  logic ext_pin_reg;
  logic t3_reg;
  logic t2_reg;
  logic pbusy_reg;

  // Bus write state
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        wr_fire;

  // Rising edge helper
  function automatic logic rose(input logic now, input logic was);
    return now && !was;
  endfunction

  // Bus write channel
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
  assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_reg[7:2] <= LINK_OFF[7:2]
                       && awaddr_reg != RESULT_OFF
                       && awaddr_reg != LINK_OFF) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Decoded writes, low byte lane only
  logic wr_ctl;
  logic wr_cfg;
  logic wr_chan;
  assign wr_ctl  = wr_fire && wstrb_reg[0]
                   && awaddr_reg[7:2] == CONTROL_OFF[7:2];
  assign wr_cfg  = wr_fire && wstrb_reg[0]
                   && awaddr_reg[7:2] == CONFIG_OFF[7:2];
  assign wr_chan = wr_fire && wstrb_reg[0]
                   && awaddr_reg[7:2] == CHANNEL_OFF[7:2];

  // Control fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      converter_enable_reg    <= 1'b0;
      track_mode_select_reg   <= 1'b0;
      start_source_select_reg <= SRC_RESET;
    end else if (wr_ctl) begin
      converter_enable_reg    <= wdata_reg[CTL_EN_BIT];
      track_mode_select_reg   <= wdata_reg[CTL_TM_BIT];
      start_source_select_reg <= wdata_reg[CTL_SRC_LSB +: 3];
    end
  end

  // Config and channel fields
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sar_clock_divider_reg <= DIV_RESET;
      gain_select_reg       <= GAIN_RESET; // RULE14
      channel_select_reg    <= CHAN_RESET;
    end else begin
      if (wr_cfg) begin
        sar_clock_divider_reg <= wdata_reg[CFG_DIV_LSB +: 5];
        gain_select_reg       <= wdata_reg[CFG_GAIN_LSB +: 2]; // RULE19
      end
      if (wr_chan) begin
        channel_select_reg <= wdata_reg[2:0]; // RULE15
      end
    end
  end

  // Trigger edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_pin_reg <= 1'b0;
      t3_reg      <= 1'b0;
      t2_reg      <= 1'b0;
      pbusy_reg   <= 1'b0;
    end else begin
      ext_pin_reg <= aux_pin_enabled ? trig.ext_start_aux
                                     : trig.ext_start_primary;
      t3_reg      <= trig.timer3_overflow;
      t2_reg      <= trig.timer2_overflow;
      pbusy_reg   <= trig.primary_converter_busy;
    end
  end

  // Start selection
  logic ext_pin;
  logic sw_start;
  logic start_evt;
  assign ext_pin  = aux_pin_enabled ? trig.ext_start_aux
                                    : trig.ext_start_primary; // RULE6
  assign sw_start = wr_ctl && wdata_reg[CTL_BUSY_BIT];

  always_comb begin
    case (start_source_select_reg) // RULE4 RULE22
      SRC_SOFTWARE: start_evt = sw_start; // RULE18
      SRC_TIMER3:   start_evt = rose(trig.timer3_overflow, t3_reg); // RULE18
      SRC_EXT_PIN:  start_evt = rose(ext_pin, ext_pin_reg); // RULE5
      SRC_TIMER2:   start_evt = rose(trig.timer2_overflow, t2_reg);
      SRC_PRIMARY:  start_evt = rose(trig.primary_converter_busy,
                                     pbusy_reg);
      default:      start_evt = 1'b0;
    endcase
  end

  asc_clk_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (converter_enable_reg), // RULE1
    .divider (sar_clock_divider_reg), // RULE2
    .tick    (tick)
  );

  // Low-power pin mode converts directly on the rising edge
  logic pin_lowpower;
  assign pin_lowpower = track_mode_select_reg
                        && start_source_select_reg == SRC_EXT_PIN;

  // Conversion sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn || !converter_enable_reg) begin // RULE1
      state_reg <= ST_IDLE;
      step_reg  <= 5'h00;
      sar_reg   <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_evt) begin
            step_reg <= 5'h00;
            if (track_mode_select_reg && !pin_lowpower) begin
              state_reg <= ST_TRACK; // RULE11
            end else begin
              state_reg <= ST_CONVERT; // RULE12
              sar_reg   <= 8'h80;
            end
          end
        end
        ST_TRACK: begin
          if (tick) begin
            if (step_reg == TRACK_PERIODS - 5'h01) begin // RULE11
              state_reg <= ST_CONVERT;
              step_reg  <= 5'h00;
              sar_reg   <= 8'h80;
            end else begin
              step_reg <= step_reg + 5'h01;
            end
          end
        end
        ST_CONVERT: begin
          if (tick) begin // RULE17
            sar_reg <= cmp_high ? sar_reg : sar_reg & ~(8'h80 >> step_reg);
            if (step_reg != RESULT_BITS - 5'h01) begin
              sar_reg[3'(7 - step_reg - 1)] <= 1'b1;
            end
            if (step_reg == RESULT_BITS - 5'h01) begin
              state_reg <= ST_IDLE;
            end
            step_reg <= step_reg + 5'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Busy falls at the last trial of a conversion
  assign busy_clear = state_reg == ST_CONVERT && tick
                      && step_reg == RESULT_BITS - 5'h01;
  assign conversion_busy = converter_enable_reg // RULE1
                           && state_reg != ST_IDLE; // RULE7 RULE21

  // Result capture and done flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_reg <= 8'h00;
    end else if (busy_clear) begin
      result_reg <= cmp_high ? sar_reg : sar_reg & 8'hFE; // RULE8
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      conversion_done_flag_reg <= 1'b0;
    end else if (busy_clear) begin
      conversion_done_flag_reg <= 1'b1; // RULE8
    end else if (wr_ctl && !wdata_reg[CTL_DONE_BIT]) begin
      conversion_done_flag_reg <= 1'b0; // RULE20
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_event <= 1'b0;
    end else begin
      done_event <= busy_clear;
    end
  end

  // Analog core controls
  always_comb begin
    analog.powered     = converter_enable_reg; // RULE1
    analog.track       = converter_enable_reg && (pin_lowpower
                         ? (state_reg == ST_IDLE && !ext_pin) // RULE12
                         : track_mode_select_reg
                         ? state_reg == ST_TRACK
                         : state_reg != ST_CONVERT); // RULE10
    analog.gain_select = gain_select_reg;
    analog.channel     = channel_select_reg;
    analog.cmp_valid   = state_reg == ST_CONVERT && tick;
    analog.trial_code  = sar_reg;
  end

  // Read channel
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    case (s_axi_araddr[7:2])
      CONTROL_OFF[7:2]: rd_word[7:0] = {converter_enable_reg,
                          track_mode_select_reg, conversion_done_flag_reg,
                          conversion_busy, start_source_select_reg, 1'b0};
      CONFIG_OFF[7:2]:  rd_word[7:0] = {sar_clock_divider_reg, 1'b0,
                                        gain_select_reg};
      CHANNEL_OFF[7:2]: rd_word[7:0] = {5'h00, channel_select_reg};
      RESULT_OFF[7:2]:  rd_word[7:0] = result_reg;
      default:          rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: testbench/asc_sar_model.sv
// Behavioural comparator of the analog SAR core
`timescale 1ns/10ps
`default_nettype none
module asc_sar_model
  import asc_pkg::*;
(
  // Clock
  input  wire logic        aclk,
  // Core controls and input level
  input  wire asc_analog_t analog,
  input  wire logic [7:0]  vin,
  // Comparator result
  output logic             cmp_high
);
  logic flip = 1'b0;

  always @(posedge aclk) begin
    flip <= ~flip;
  end

  // Outside a trial the level keeps changing, never a stale answer
  assign cmp_high = (analog.powered && analog.cmp_valid) ?
                    (vin >= analog.trial_code) : flip;
endmodule
`default_nettype wire

// File: testbench/asc_conv_ctrl_assertions.sv
// Concurrent checks on the converter control ports
`timescale 1ns/10ps
`default_nettype none
module asc_conv_ctrl_assertions
  import asc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Converter side
  input  wire asc_analog_t analog,
  input  wire logic        conversion_busy,
  input  wire logic        done_event
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence conv_begin;
    $rose(conversion_busy);
  endsequence

  sequence conv_end;
    $fell(conversion_busy) && analog.powered;
  endsequence

  reset_state_a: assert property ($rose(aresetn) |->
    !conversion_busy && !analog.powered && !done_event &&
    analog.gain_select == GAIN_RESET) else $error("bad reset state");
  off_idle_a: assert property (!analog.powered |->
    !conversion_busy && !analog.cmp_valid) else $error("active when off");
  busy_min_a: assert property (conv_begin |->
    (conversion_busy || !analog.powered)[*8]) else $error("busy too short");
  busy_end_a: assert property (conv_begin |->
    ##[8:1000] !conversion_busy) else $error("busy never ends");
  done_after_a: assert property (conv_end |-> done_event)
    else $error("no done after busy fell");
  done_pulse_a: assert property (done_event |=> !done_event)
    else $error("done longer than one cycle");
  done_cause_a: assert property (done_event |->
    $past(conversion_busy) && !conversion_busy)
    else $error("done without busy fall");
  cmp_hold_a: assert property (analog.cmp_valid |->
    conversion_busy && !analog.track) else $error("trial while tracking");
endmodule

bind asc_conv_ctrl asc_conv_ctrl_assertions asc_conv_ctrl_assertions_i (
  .aclk            (aclk),
  .aresetn         (aresetn),
  .analog          (analog),
  .conversion_busy (conversion_busy),
  .done_event      (done_event)
);
`default_nettype wire

// File: testbench/test_asc_conv_ctrl.sv
// Self-checking bench for the aux converter control
`timescale 1ns/10ps
`default_nettype none
module test_asc_conv_ctrl
  import asc_pkg::*;
;
  logic        aclk, aresetn, aux_pin_enabled, cmp_high;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, vin;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, conversion_busy, done_event;
  asc_trig_t   trig;
  asc_analog_t analog;
  int          error_cnt, n_checks, cyc, blen, last_len, n_done, n0;
  logic [7:0]  vt [3] = '{8'h00, 8'hA5, 8'hFF};
  logic [2:0]  sv [6] = '{SRC_SOFTWARE, SRC_TIMER3, SRC_EXT_PIN,
                          SRC_TIMER2, SRC_PRIMARY, SRC_EXT_PIN};
  logic [4:0]  gv [6] = '{5'h00, 5'h10, 5'h02, 5'h08, 5'h04, 5'h01};

  asc_conv_ctrl asc_conv_ctrl_i (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig,
    .aux_pin_enabled, .analog, .cmp_high, .conversion_busy, .done_event);
  asc_sar_model asc_sar_model_i (.aclk, .analog, .vin, .cmp_high);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
  endtask

  task automatic pulse(input logic [4:0] t);
    n0 = n_done;
    trig <= t;
    repeat (2) @(posedge aclk);
    trig <= '0;
  endtask

  task automatic wt(input logic exp);
    for (int i = 0; i < 600 && n_done == n0; i++) @(posedge aclk);
    chk(n_done != n0, exp);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (conversion_busy === 1'b1) blen++;
    else if (blen != 0) begin
      last_len = blen;
      blen = 0;
    end
    if (done_event === 1'b1) n_done++;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  initial begin
    aresetn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    s_axi_wstrb <= 4'hF;
    trig <= '0;
    aux_pin_enabled <= 1'b1;
    vin <= 8'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_reg(CONTROL_OFF);
    chk(rd, 32'h0);
    rd_reg(CONFIG_OFF);
    chk(rd, 32'hF8);
    rd_reg(8'h14);
    chk(rs, RESP_SLVERR);
    wr(RESULT_OFF, 32'h0);
    chk(rs, RESP_SLVERR);
    for (int g = 0; g < 4; g++) begin
      wr(CONFIG_OFF, {24'h0, 5'h0E, 1'b0, g[1:0]});
      chk(analog.gain_select, g);
    end
    for (int c = 0; c < 8; c++) begin
      wr(CHANNEL_OFF, c);
      chk(analog.channel, c);
    end
    repeat (80) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      vin <= vt[i];
      wr(CONTROL_OFF, 32'h80);
      n0 = n_done;
      wr(CONTROL_OFF, 32'h90);
      chk(analog.track, 0);
      wt(1);
      chk(last_len >= 105 && last_len <= 121, 1);
      rd_reg(CONTROL_OFF);
      chk(rd[5:4], 2'h2);
      rd_reg(RESULT_OFF);
      chk(rd, {24'h0, vt[i]});
      chk(analog.track, 1);
    end
    wr(CONTROL_OFF, 32'hA0);
    repeat (20) @(posedge aclk);
    rd_reg(CONTROL_OFF);
    chk(rd[5], 1);
    n0 = n_done;
    wr(CONTROL_OFF, 32'h90);
    wr(CONTROL_OFF, 32'h90);
    wt(1);
    chk(last_len >= 105 && last_len <= 121, 1);
    n0 = n_done;
    wt(0);
    for (int k = 0; k < 6; k++) begin
      aux_pin_enabled <= (k != 5);
      wr(CONTROL_OFF, {24'h0, 4'h8, sv[k], 1'b0});
      pulse(~gv[k]);
      wt(0);
      if (k != 0) begin
        pulse(gv[k]);
        wt(1);
      end
    end
    aux_pin_enabled <= 1'b1;
    n0 = n_done;
    wr(CONTROL_OFF, 32'hC0);
    wr(CONTROL_OFF, 32'hD0);
    wt(1);
    chk(last_len >= 150 && last_len <= 166, 1);
    wr(CONTROL_OFF, 32'hC4);
    repeat (5) @(posedge aclk);
    chk(analog.track, 1);
    pulse(5'h02);
    repeat (2) @(posedge aclk);
    chk(analog.track, 0);
    wt(1);
    wr(CONTROL_OFF, 32'h80);
    n0 = n_done;
    wr(CONTROL_OFF, 32'h90);
    chk(conversion_busy, 1);
    wr(CONTROL_OFF, 32'h10);
    chk(analog.powered, 0);
    chk(conversion_busy, 0);
    wt(0);
    report_and_stop();
  end
endmodule
`default_nettype wire
